// [hw/line_card_map.vh]
// What this block does
// - Write is eight clocks, direction low
// - Sample rising clock, latch on select rise
// - Read shifts five status bits out
// - Bit 0 picks conversation or stand-by
// - Bit 1 gates signal injection timing
// - Bit 2 picks ringing or metering
// - Bit 3 picks metering amplitude
// - Bit 4 polarity, bit 5 boosted feed
// - Bits 6,7 pick current limit
// - Stand-by 7 mA limit mode decode
// - Ringing mode decode
// - Ringing starts at zero, stops at zero or at once on loop closure
// - Ring trip confirmed over two periods
// - Status bit 0 is hook state
// - Status bit 1 is ground key
// - Status bit 2 limiter in conversation
// - Status bit 3 low line voltage
// - Status bit 4 thermal overload
// - Select pin may output hook or key
// - Serial operation only
// - All-zero command is power-down denial
`ifndef LINE_CARD_MAP_VH
`define LINE_CARD_MAP_VH
`define CMD_W          8
`define STAT_W         5
`define CNT_W          4
`define CMD_WRITE_BITS 4'h8
`define STAT_READ_BITS 4'h5
`define CMD_RESET      8'h00
`define B_IMP          0
`define B_TIMING       1
`define B_RING         2
`define B_METER        3
`define B_POL          4
`define B_FEED         5
`define B_ILO          6
`define B_IHI          7
`define S_HOOK         0
`define S_GKEY         1
`define S_LIM          2
`define S_LOWV         3
`define S_OVT          4
`define ILIM_25MA      2'h0
`define ILIM_30MA      2'h2
`define ILIM_45MA      2'h3
`define ILIM_70MA      2'h1
`define RING_CONFIRM_PERIODS 2'h2
`endif

// [hw/ring_sequencer.v]
`include "line_card_map.vh"
`default_nettype none
// Ringing burst sequencer with zero-crossing gating and trip check
module ring_sequencer (
    // Clock and reset
    input  wire I_CORE_CLK,
    input  wire I_RST_N,
    // Control and sensed line
    input  wire i_ring_req,
    input  wire i_zero_cross,
    input  wire i_period_mark,
    input  wire i_loop_closed,
    // Results
    output reg  o_ring_on,
    output reg  o_trip
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RING = 4'h2;
    localparam [3:0] ST_CHK  = 4'h4;
    localparam [3:0] ST_TRIP = 4'h8;

    reg [3:0] state_r;
    reg [1:0] per_r;

    // ************************************************
    // State machine
    // ************************************************
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_r   <= ST_IDLE;
            per_r     <= 2'h0;
            o_ring_on <= 1'b0;
            o_trip    <= 1'b0;
        end else begin
            case (state_r)
            ST_IDLE: begin
                o_trip <= 1'b0;
                if (i_ring_req && i_zero_cross) begin
                    o_ring_on <= 1'b1;
                    state_r   <= ST_RING;
                end
            end
            ST_RING: begin
                if (i_loop_closed) begin
                    o_ring_on <= 1'b0;
                    per_r     <= 2'h0;
                    state_r   <= ST_CHK;
                end else if (!i_ring_req && i_zero_cross) begin
                    o_ring_on <= 1'b0;
                    state_r   <= ST_IDLE;
                end
            end
            ST_CHK: begin
                if (!i_ring_req) begin
                    state_r <= ST_IDLE;
                end else if (!i_loop_closed) begin
                    state_r <= ST_IDLE; // Resume at next zero
                end else if (i_period_mark) begin
                    if (per_r == `RING_CONFIRM_PERIODS - 2'h1) begin
                        o_trip  <= 1'b1;
                        state_r <= ST_TRIP;
                    end
                    per_r <= per_r + 2'h1;
                end
            end
            ST_TRIP: begin
                // Wait for a new command that drops ringing
                if (!i_ring_req) begin
                    o_trip  <= 1'b0;
                    state_r <= ST_IDLE;
                end
            end
            default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // ring_sequencer
`default_nettype wire

// [hw/line_card_serial_control_port.v]
`include "line_card_map.vh"
`default_nettype none
// Serial control port of a subscriber-line control unit (serial mode)
module line_card_serial_control_port (
    // Clock and reset
    input  wire       I_CORE_CLK,
    input  wire       I_RST_N,
    // Serial link pins
    input  wire       I_SERIAL_CLOCK_IN,
    input  wire       I_TRANSFER_DIRECTION,
    input  wire       I_SELECT_N,
    input  wire       I_SELECT_PIN_ROLE,
    input  wire       I_SERIAL_DATA_IO,
    output reg        O_SERIAL_DATA_IO,
    output reg        O_SERIAL_DATA_IO_OE,
    output reg        O_SELECT_N,
    output reg        O_SELECT_N_OE,
    // Line sensors
    input  wire       I_OFF_HOOK,
    input  wire       I_GROUND_KEY,
    input  wire       I_IN_LIMIT_REGION,
    input  wire       I_LOW_LINE_VOLTAGE,
    input  wire       I_OVERTEMP,
    input  wire       I_RING_ZERO_CROSS,
    input  wire       I_RING_PERIOD_MARK,
    // Line control outputs
    output reg  [7:0] O_LINE_COMMAND,
    output reg        O_STANDBY_STATE,
    output reg        O_CONVERSATION_STATE,
    output reg        O_RINGING_STATE,
    output reg        O_POWER_DOWN_DENIAL,
    output reg        O_METERING_PULSE,
    output reg        O_RING_INJECT,
    output reg        O_METER_HIGH_LEVEL,
    output reg        O_REVERSE_POLARITY,
    output reg        O_BOOSTED_FEED,
    output reg        O_NORMAL_FEED,
    output reg  [1:0] O_CURRENT_LIMIT,
    output reg        O_STANDBY_7MA,
    output reg        O_SENSORS_ENABLE,
    output reg  [4:0] O_LINE_STATUS
);
    // ************************************************
    // Synchronisers
    // ************************************************
    reg [1:0] clk_s_r, dir_s_r, sel_s_r, role_s_r, din_s_r;
    reg [4:0] sens1_r, sens2_r;
    reg [1:0] zc_s_r, pm_s_r;
    reg       clk_d_r, sel_d_r, zc_d_r, pm_d_r;

    // Two flops on every outside input
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            clk_s_r  <= 2'h0;
            dir_s_r  <= 2'h0;
            sel_s_r  <= 2'h3;
            role_s_r <= 2'h0;
            din_s_r  <= 2'h0;
            sens1_r  <= 5'h00;
            sens2_r  <= 5'h00;
            zc_s_r   <= 2'h0;
            pm_s_r   <= 2'h0;
            clk_d_r  <= 1'b0;
            sel_d_r  <= 1'b1;
            zc_d_r   <= 1'b0;
            pm_d_r   <= 1'b0;
        end else begin
            clk_s_r  <= {clk_s_r[0], I_SERIAL_CLOCK_IN};
            dir_s_r  <= {dir_s_r[0], I_TRANSFER_DIRECTION};
            sel_s_r  <= {sel_s_r[0], I_SELECT_N};
            role_s_r <= {role_s_r[0], I_SELECT_PIN_ROLE};
            din_s_r  <= {din_s_r[0], I_SERIAL_DATA_IO};
            sens1_r  <= {I_OVERTEMP, I_LOW_LINE_VOLTAGE, I_IN_LIMIT_REGION,
                         I_GROUND_KEY, I_OFF_HOOK};
            sens2_r  <= sens1_r;
            zc_s_r   <= {zc_s_r[0], I_RING_ZERO_CROSS};
            pm_s_r   <= {pm_s_r[0], I_RING_PERIOD_MARK};
            clk_d_r  <= clk_s_r[1];
            sel_d_r  <= sel_s_r[1];
            zc_d_r   <= zc_s_r[1];
            pm_d_r   <= pm_s_r[1];
        end
    end

    // Edge detection on synchronised levels
    wire role_out  = role_s_r[1];
    wire sel_n     = role_out ? 1'b1 : sel_s_r[1];
    wire sel_was_n = role_out ? 1'b1 : sel_d_r;
    wire clk_rise  = clk_s_r[1] & ~clk_d_r;
    wire clk_fall  = ~clk_s_r[1] & clk_d_r;
    wire sel_fall  = ~sel_n & sel_was_n;
    wire sel_rise  = sel_n & ~sel_was_n;
    wire zc_rise   = zc_s_r[1] & ~zc_d_r;
    wire pm_rise   = pm_s_r[1] & ~pm_d_r;

    // ************************************************
    // Serial shifter
    // ************************************************
    reg [7:0] shift_r;
    reg [3:0] cnt_r;
    reg       is_read_r;
    reg       bad_r;
    reg [4:0] out_sh_r;
    reg [7:0] cmd_r;
    reg [4:0] status_r;

    // Shift, count and latch on select rise
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            shift_r   <= `CMD_RESET;
            cnt_r     <= 4'h0;
            is_read_r <= 1'b0;
            bad_r     <= 1'b0;
            out_sh_r  <= 5'h00;
            cmd_r     <= `CMD_RESET;
        end else if (sel_fall) begin
            cnt_r     <= 4'h0;
            is_read_r <= dir_s_r[1];
            bad_r     <= 1'b0;
            out_sh_r  <= status_r; // Snapshot for the read
        end else if (!sel_n) begin
            // Direction change mid-frame spoils a write
            if (!is_read_r && dir_s_r[1])
                bad_r <= 1'b1;
            if (clk_rise && !is_read_r) begin
                shift_r <= {din_s_r[1], shift_r[7:1]};
                if (cnt_r != 4'hf)
                    cnt_r <= cnt_r + 4'h1;
            end
            if (clk_fall && is_read_r)
                out_sh_r <= {1'b0, out_sh_r[4:1]};
        end else if (sel_rise && !is_read_r && !bad_r) begin
            if (cnt_r == `CMD_WRITE_BITS)
                cmd_r <= shift_r;
        end
    end

    // ************************************************
    // Command decode
    // ************************************************
    wire conv     = cmd_r[`B_IMP];
    wire ilim_any = cmd_r[`B_ILO] | cmd_r[`B_IHI];
    wire pdd      = (cmd_r == `CMD_RESET);
    wire ring_md  = ~conv & cmd_r[`B_RING]
                    & (cmd_r[`B_FEED] | ilim_any);
    wire ring_req = ring_md & cmd_r[`B_TIMING];
    wire ring_on;
    wire ring_trip;

    // Ringing sequencer
    ring_sequencer u_ring (
        .I_CORE_CLK   (I_CORE_CLK),
        .I_RST_N      (I_RST_N),
        .i_ring_req   (ring_req),
        .i_zero_cross (zc_rise),
        .i_period_mark(pm_rise),
        .i_loop_closed(sens2_r[`S_HOOK]),
        .o_ring_on    (ring_on),
        .o_trip       (ring_trip)
    );

    // Status word assembly
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            status_r <= 5'h00;
        end else begin
            status_r[`S_HOOK] <= pdd ? 1'b0 :
                ((ring_md & ~conv) ? ring_trip
                                   : sens2_r[`S_HOOK]);
            status_r[`S_GKEY] <= pdd ? 1'b0 : sens2_r[`S_GKEY];
            status_r[`S_LIM]  <= conv & sens2_r[`S_LIM];
            status_r[`S_LOWV] <= sens2_r[`S_LOWV];
            status_r[`S_OVT]  <= sens2_r[`S_OVT];
        end
    end

    // ************************************************
    // Registered outputs
    // ************************************************
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SERIAL_DATA_IO     <= 1'b0;
            O_SERIAL_DATA_IO_OE  <= 1'b0;
            O_SELECT_N           <= 1'b0;
            O_SELECT_N_OE        <= 1'b0;
            O_LINE_COMMAND       <= `CMD_RESET;
            O_STANDBY_STATE      <= 1'b1;
            O_CONVERSATION_STATE <= 1'b0;
            O_RINGING_STATE      <= 1'b0;
            O_POWER_DOWN_DENIAL  <= 1'b1;
            O_METERING_PULSE     <= 1'b0;
            O_RING_INJECT        <= 1'b0;
            O_METER_HIGH_LEVEL   <= 1'b0;
            O_REVERSE_POLARITY   <= 1'b0;
            O_BOOSTED_FEED       <= 1'b0;
            O_NORMAL_FEED        <= 1'b1;
            O_CURRENT_LIMIT      <= `ILIM_25MA;
            O_STANDBY_7MA        <= 1'b0;
            O_SENSORS_ENABLE     <= 1'b0;
            O_LINE_STATUS        <= 5'h00;
        end else begin
            // Data pin driven only during a read
            O_SERIAL_DATA_IO    <= out_sh_r[0];
            O_SERIAL_DATA_IO_OE <= ~sel_n & is_read_r
                                   & dir_s_r[1] & ~sel_fall;
            // Select pin as hook or key output
            O_SELECT_N    <= status_r[`S_HOOK] | status_r[`S_GKEY];
            O_SELECT_N_OE <= role_out;
            O_LINE_COMMAND       <= cmd_r;
            O_STANDBY_STATE      <= ~conv & ~ring_md;
            O_CONVERSATION_STATE <= conv;
            O_RINGING_STATE      <= ring_md;
            O_POWER_DOWN_DENIAL  <= pdd;
            O_METERING_PULSE     <= conv & cmd_r[`B_TIMING]
                                    & ~cmd_r[`B_RING];
            O_RING_INJECT        <= ring_on;
            O_METER_HIGH_LEVEL   <= cmd_r[`B_METER];
            O_REVERSE_POLARITY   <= conv & cmd_r[`B_POL];
            O_BOOSTED_FEED       <= conv & cmd_r[`B_FEED];
            O_NORMAL_FEED        <= ~(conv & cmd_r[`B_FEED]);
            O_CURRENT_LIMIT      <= {cmd_r[`B_IHI], cmd_r[`B_ILO]};
            O_STANDBY_7MA        <= ~conv & ilim_any;
            O_SENSORS_ENABLE     <= ~pdd;
            O_LINE_STATUS        <= status_r;
        end
    end
endmodule // line_card_serial_control_port
`default_nettype wire

// [testbench/line_card_ctrl_model.sv]
`default_nettype none
// Card controller model driving the serial control wires
module line_card_ctrl_model (
    // Core clock for pacing
    input  wire logic i_clk,
    // Serial wires
    input  wire logic i_data,
    output var logic  o_sclk,
    output var logic  o_dir,
    output var logic  o_sel_n,
    output var logic  o_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle levels: clock still, deselected
    initial begin
        {o_sclk, o_dir, o_sel_n, o_data} = 4'h2;
    end

    // Wait a number of core cycles
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // One frame of n bits, least significant first
    task automatic xfer(input logic rd, input logic [7:0] w,
                        input int n, output logic [7:0] r);
        r = 8'h00;
        o_dir <= rd;
        wt(4);
        o_sel_n <= 1'b0;
        wt(8);
        for (int i = 0; i < n; i++) begin
            if (!rd) o_data <= w[i];
            wt(4);
            r[i] = i_data;
            o_sclk <= 1'b1;
            wt(4);
            o_sclk <= 1'b0;
            wt(4);                          // Low phase, 120 ns period
        end
        o_sel_n <= 1'b1;
        o_data <= ~o_data;                  // Stale value never lingers
        wt(8);
    endtask
endmodule // line_card_ctrl_model
`default_nettype wire

// [testbench/line_card_serial_control_port_checker.sv]
`default_nettype none
// Pin-level properties of the serial control port
module line_card_serial_control_port_checker (
    input wire logic       I_CORE_CLK,
    input wire logic       I_RST_N,
    input wire logic       I_SELECT_N,
    input wire logic       I_TRANSFER_DIRECTION,
    input wire logic       I_SELECT_PIN_ROLE,
    input wire logic       I_GROUND_KEY,
    input wire logic       I_LOW_LINE_VOLTAGE,
    input wire logic       I_OVERTEMP,
    input wire logic       O_SERIAL_DATA_IO_OE,
    input wire logic       O_SELECT_N_OE,
    input wire logic [7:0] O_LINE_COMMAND,
    input wire logic       O_CONVERSATION_STATE,
    input wire logic       O_METERING_PULSE,
    input wire logic       O_REVERSE_POLARITY,
    input wire logic       O_BOOSTED_FEED,
    input wire logic [1:0] O_CURRENT_LIMIT,
    input wire logic       O_STANDBY_7MA,
    input wire logic       O_POWER_DOWN_DENIAL,
    input wire logic [4:0] O_LINE_STATUS
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    // Command held long enough for its decode to land
    sequence cmd_settled;
        $stable(O_LINE_COMMAND)[*3];
    endsequence

    a_oe_only_read: assert property (
        (I_SELECT_N || !I_TRANSFER_DIRECTION)[*4] |-> !O_SERIAL_DATA_IO_OE)
        else $error("data driven outside read");
    a_cmd_hold: assert property (I_SELECT_N[*7] |=> $stable(O_LINE_COMMAND))
        else $error("command changed while deselected");
    a_conv_decode: assert property (cmd_settled |-> O_CONVERSATION_STATE
        == O_LINE_COMMAND[0]) else $error("conversation decode wrong");
    a_meter_decode: assert property (cmd_settled |->
        O_METERING_PULSE == (O_LINE_COMMAND[2:0] == 3'h3))
        else $error("metering decode wrong");
    a_feed_pol: assert property (cmd_settled |-> {O_BOOSTED_FEED,
        O_REVERSE_POLARITY} == ({2{O_LINE_COMMAND[0]}} & O_LINE_COMMAND[5:4]))
        else $error("feed or polarity decode wrong");
    a_ilimit_code: assert property (cmd_settled |-> O_CURRENT_LIMIT ==
        {O_LINE_COMMAND[7], O_LINE_COMMAND[6]}) else $error("limit code wrong");
    a_standby_7ma: assert property (cmd_settled |-> O_STANDBY_7MA ==
        (!O_LINE_COMMAND[0] && |O_LINE_COMMAND[7:6])) else $error("7ma wrong");
    a_pdd_decode: assert property (cmd_settled |->
        O_POWER_DOWN_DENIAL == (O_LINE_COMMAND == 8'h00))
        else $error("power-down decode wrong");
    a_status_map: assert property (
        $stable({I_OVERTEMP, I_LOW_LINE_VOLTAGE, I_GROUND_KEY})[*5] |->
        {O_LINE_STATUS[4:3], O_LINE_STATUS[1]} ==
        {I_OVERTEMP, I_LOW_LINE_VOLTAGE, I_GROUND_KEY})
        else $error("status bits wrong");
    a_select_role: assert property ($stable(I_SELECT_PIN_ROLE)[*4] |->
        O_SELECT_N_OE == I_SELECT_PIN_ROLE) else $error("select role wrong");
endmodule // line_card_serial_control_port_checker
`default_nettype wire

// [testbench/line_card_serial_control_port_tb_top.sv]
`default_nettype none
// Self-checking bench for the serial control port
module line_card_serial_control_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, role, hook, gkey, lim, lowv, ovt, zc, pm;
    logic sclk, dir, sel_n, mdata, sdo, sdo_oe, selo, selo_oe, stby, conv;
    logic ring, pdd, mpulse, rinj, mhi, rpol, boost, nfeed, s7, sens;
    logic [7:0] cmd, rd;
    logic [1:0] ilim;
    logic [4:0] stat;
    int error_cnt = 0, comparisons = 0;
    // Command word beside its expected {limit, 7ma, conversation, pdd}
    logic [12:0] rows [5] = '{{8'h00, 5'h01}, {8'h41, 5'h0a},
        {8'hc0, 5'h1c}, {8'h80, 5'h14}, {8'h3b, 5'h02}};
    wire logic sdi = sdo_oe ? sdo : mdata;

    always #5 clk = ~clk;

    line_card_serial_control_port dut (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_SERIAL_CLOCK_IN(sclk), .I_TRANSFER_DIRECTION(dir),
        .I_SELECT_N(sel_n), .I_SELECT_PIN_ROLE(role), .I_SERIAL_DATA_IO(sdi),
        .O_SERIAL_DATA_IO(sdo), .O_SERIAL_DATA_IO_OE(sdo_oe),
        .O_SELECT_N(selo), .O_SELECT_N_OE(selo_oe), .I_OFF_HOOK(hook),
        .I_GROUND_KEY(gkey), .I_IN_LIMIT_REGION(lim), .I_OVERTEMP(ovt),
        .I_LOW_LINE_VOLTAGE(lowv), .I_RING_ZERO_CROSS(zc),
        .I_RING_PERIOD_MARK(pm), .O_LINE_COMMAND(cmd), .O_STANDBY_STATE(stby),
        .O_CONVERSATION_STATE(conv), .O_RINGING_STATE(ring),
        .O_POWER_DOWN_DENIAL(pdd), .O_METERING_PULSE(mpulse),
        .O_RING_INJECT(rinj), .O_METER_HIGH_LEVEL(mhi),
        .O_REVERSE_POLARITY(rpol), .O_BOOSTED_FEED(boost),
        .O_NORMAL_FEED(nfeed), .O_CURRENT_LIMIT(ilim), .O_STANDBY_7MA(s7),
        .O_SENSORS_ENABLE(sens), .O_LINE_STATUS(stat));

    line_card_ctrl_model m (.i_clk(clk), .i_data(sdi), .o_sclk(sclk),
        .o_dir(dir), .o_sel_n(sel_n), .o_data(mdata));

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Pulse a zero crossing or a period mark
    task automatic pz(input logic p);
        if (p) pm <= 1'b1; else zc <= 1'b1;
        wt(6);
        {zc, pm} <= 2'h0;
        wt(6);
    endtask

    task automatic conclude;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Watchdog far beyond the expected run
    initial begin
        wt(20000);
        error_cnt++;
        conclude;
    end

    initial begin
        {role, hook, gkey, lim, lowv, ovt, zc, pm} = 8'h00;
        wt(10);
        rst_n <= 1'b1;
        wt(4);
        chk("reset state", 8'h16, {cmd[0], pdd, sens, nfeed, stby, mhi});
        for (int k = 0; k < 5; k++) begin
            m.xfer(1'b0, rows[k][12:5], 8, rd);
            wt(6);
            chk("command", rows[k][12:5], cmd);
            chk("mode", rows[k][4:0], {ilim, s7, conv, pdd});
        end
        chk("meter level", 8'h01, {stby, mhi});
        m.xfer(1'b0, 8'hff, 7, rd);
        wt(8);
        chk("short write", 8'h3b, cmd);
        {ovt, lowv, lim, gkey, hook} <= 5'h15;
        wt(6);
        m.xfer(1'b1, 8'h00, 5, rd);
        chk("status read", 8'h15, rd);
        m.xfer(1'b1, 8'h00, 2, rd);
        chk("partial read", 8'h01, rd);
        chk("data released", 8'h00, sdo_oe);
        {role, hook, gkey} <= 3'h5;
        wt(8);
        chk("select out", 8'h03, {selo_oe, selo});
        {hook, gkey} <= 2'h0;
        wt(8);
        chk("select low", 8'h02, {selo_oe, selo});
        role <= 1'b0;
        wt(8);
        m.xfer(1'b0, 8'h86, 8, rd);
        wt(6);
        chk("ring wait", 8'h02, {ring, rinj});
        pz(1'b0);
        chk("ring start", 8'h01, rinj);
        hook <= 1'b1;
        wt(6);
        pz(1'b1);
        chk("trip pending", 8'h00, stat[0]);
        pz(1'b1);
        chk("trip set", 8'h01, {rinj, stat[0]});
        conclude;
    end
endmodule // line_card_serial_control_port_tb_top

bind line_card_serial_control_port
    line_card_serial_control_port_checker chk_i (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_SELECT_N(I_SELECT_N),
    .I_TRANSFER_DIRECTION(I_TRANSFER_DIRECTION), .I_OVERTEMP(I_OVERTEMP),
    .I_SELECT_PIN_ROLE(I_SELECT_PIN_ROLE), .I_GROUND_KEY(I_GROUND_KEY),
    .I_LOW_LINE_VOLTAGE(I_LOW_LINE_VOLTAGE), .O_SELECT_N_OE(O_SELECT_N_OE),
    .O_SERIAL_DATA_IO_OE(O_SERIAL_DATA_IO_OE), .O_LINE_COMMAND(O_LINE_COMMAND),
    .O_CONVERSATION_STATE(O_CONVERSATION_STATE), .O_LINE_STATUS(O_LINE_STATUS),
    .O_METERING_PULSE(O_METERING_PULSE), .O_BOOSTED_FEED(O_BOOSTED_FEED),
    .O_REVERSE_POLARITY(O_REVERSE_POLARITY), .O_STANDBY_7MA(O_STANDBY_7MA),
    .O_CURRENT_LIMIT(O_CURRENT_LIMIT),
    .O_POWER_DOWN_DENIAL(O_POWER_DOWN_DENIAL));
`default_nettype wire
